// ---- core/dbc_consts.svh ----
// constants of the disc block cache manager
`ifndef DBC_CONSTS_SVH
`define DBC_CONSTS_SVH
`define DBC_NUM_SLOTS 64
`define DBC_SLOT_W 6
`define DBC_HALF_SLOTS 6'h20
`define DBC_LBA_W 26
`define DBC_DRV_W 2
`define DBC_DATA_W 16
`define DBC_CNT_W 8
`define DBC_IDX_W 9
`define DBC_BIAS_D0 6'h00
`define DBC_BIAS_D1 6'h11
`define DBC_BIAS_D2 6'h22
`define DBC_BIAS_D3 6'h33
`define DBC_REG_ADDR_W 8
`define DBC_REG_DATA_W 32
`define DBC_REG_CTRL 8'h00
`define DBC_REG_LOOKAHEAD 8'h04
`define DBC_REG_STATUS 8'h08
`define DBC_CTRL_W 2
`define DBC_CTRL_CACHE_EN 0
`define DBC_CTRL_EARLY 1
`define DBC_CTRL_RESET 2'h3
`define DBC_LOOKAHEAD_RESET 8'h04
`endif

// ---- core/dbc_pkg.sv ----
// types shared by the disc block cache manager
`include "dbc_consts.svh"
package dbc_pkg;
	typedef enum logic [3:0] {
		S_IDLE = 4'b0000,
		S_LOOKUP = 4'b0001,
		S_HIT_XFER = 4'b0010,
		S_ALLOC = 4'b0011,
		S_DISC_RD = 4'b0100,
		S_DELIVER = 4'b0101,
		S_WR_HOST = 4'b0110,
		S_DISC_WR = 4'b0111,
		S_EVICT = 4'b1000,
		S_FLUSH = 4'b1001,
		S_NEXT = 4'b1010,
		S_DONE = 4'b1011
	} state_e;

	typedef struct packed {
		logic locked;
		logic valid;
		logic pri_dirty;
		logic shadow_dirty;
		logic [`DBC_DRV_W-1:0] drive;
		logic [`DBC_LBA_W-1:0] lba;
	} map_entry_s;

	typedef struct packed {
		logic req;
		logic write;
		logic [`DBC_DRV_W-1:0] drive;
		logic [`DBC_LBA_W-1:0] lba;
		logic [`DBC_DATA_W-1:0] wdata;
	} disc_cmd_s;

	function automatic logic [`DBC_SLOT_W-1:0] drive_bias(input logic [`DBC_DRV_W-1:0] d);
		case (d)
			2'h0: drive_bias = `DBC_BIAS_D0;
			2'h1: drive_bias = `DBC_BIAS_D1;
			2'h2: drive_bias = `DBC_BIAS_D2;
			default: drive_bias = `DBC_BIAS_D3;
		endcase
	endfunction
endpackage

// ---- core/slot_hash_if.sv ----
// block address to cache slot hashing signals
`include "dbc_consts.svh"
interface slot_hash_if;
	logic [`DBC_DRV_W-1:0] drive;
	logic [`DBC_LBA_W-1:0] lba;
	logic [`DBC_SLOT_W-1:0] primary;
	logic [`DBC_SLOT_W-1:0] alternate;
	modport requester(output drive, output lba, input primary, input alternate);
	modport hasher(input drive, input lba, output primary, output alternate);
endinterface

// ---- core/slot_hash.sv ----
// primary and alternate cache slot of a disc block
`include "dbc_consts.svh"
module slot_hash (
	slot_hash_if.hasher h
);
	function automatic logic [`DBC_SLOT_W-1:0] wrap(input logic [`DBC_SLOT_W:0] v);
		if (v >= (`DBC_SLOT_W+1)'(`DBC_NUM_SLOTS))
			wrap = `DBC_SLOT_W'(v - (`DBC_SLOT_W+1)'(`DBC_NUM_SLOTS));
		else
			wrap = `DBC_SLOT_W'(v);
	endfunction

	logic [`DBC_SLOT_W-1:0] rem;

	// remainder of block number by slot count
	assign rem = `DBC_SLOT_W'(h.lba % `DBC_LBA_W'(`DBC_NUM_SLOTS));
	// per drive bias fixed at build time
	assign h.primary = wrap({1'b0, rem} + {1'b0, dbc_pkg::drive_bias(h.drive)});
	assign h.alternate = wrap({1'b0, h.primary} + {1'b0, `DBC_HALF_SLOTS});
endmodule

// ---- core/disc_block_cache_manager.sv ----
// write-back disc block cache manager: slot map, data store, sequencing
`include "dbc_consts.svh"
//////////////////////////////////////////////////////////////////////////////
// Behaviour
// - primary slot begins as block number modulo slot count
// - primary slot is biased by a fixed per-drive offset
// - alternate slot is primary displaced by about half the slots
// - alternate slot is used only for compares, never for allocation
// - read with every block present is served from cache, no disc access
// - assigned slots are locked; a locked slot stalls allocation
// - read miss: lock, disc read, then unlock and mark valid
// - write: lock, host data into cache, mark valid, disc write, unlock
// - one global setting turns caching off for all drives
// - early notify: report write done at once, write disc later
// - option disables early notify; completion waits for disc write
// - four byte map entry: drive, block, locked, valid, two unwritten flags
// - look-ahead count 0 to 255, default four, zero disables
// - all disc traffic goes through cache, in contiguous slots
module disc_block_cache_manager (
	input wire logic ref_clk_i,
	input wire logic resetn_i,
	input wire logic [`DBC_REG_ADDR_W-1:0] reg_addr_i,
	input wire logic [`DBC_REG_DATA_W-1:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [`DBC_REG_DATA_W-1:0] reg_rdata_o,
	input wire logic req_valid_i,
	input wire logic req_write_i,
	input wire logic [`DBC_DRV_W-1:0] req_drive_i,
	input wire logic [`DBC_LBA_W-1:0] req_lba_i,
	input wire logic [`DBC_CNT_W-1:0] req_count_i,
	output logic busy_o,
	output logic done_o,
	output logic host_rd_valid_o,
	output logic [`DBC_DATA_W-1:0] host_rdata_o,
	input wire logic host_wr_valid_i,
	input wire logic [`DBC_DATA_W-1:0] host_wdata_i,
	output logic host_wr_ready_o,
	output logic disc_req_o,
	output logic disc_write_o,
	output logic [`DBC_DRV_W-1:0] disc_drive_o,
	output logic [`DBC_LBA_W-1:0] disc_lba_o,
	output logic [`DBC_DATA_W-1:0] disc_wdata_o,
	input wire logic disc_ack_i,
	input wire logic [`DBC_DATA_W-1:0] disc_rdata_i
);
	dbc_pkg::map_entry_s map [`DBC_NUM_SLOTS];
	logic [`DBC_DATA_W-1:0] dat [`DBC_NUM_SLOTS];
	dbc_pkg::state_e state, next_state;
	dbc_pkg::disc_cmd_s disc, next_disc;
	logic op_write, next_op_write;
	logic [`DBC_DRV_W-1:0] cur_drive, next_cur_drive;
	logic [`DBC_LBA_W-1:0] base_lba, next_base_lba, cur_lba;
	logic [`DBC_CNT_W-1:0] count, next_count;
	logic [`DBC_IDX_W-1:0] idx, next_idx, total, next_total;
	logic [`DBC_SLOT_W-1:0] cur_slot, next_cur_slot, flush_ptr, next_flush_ptr, hit_slot;
	logic next_done, next_rd_valid, next_wr_ready;
	logic [`DBC_DATA_W-1:0] next_rdata;
	logic map_we, dat_we;
	logic [`DBC_SLOT_W-1:0] map_idx, dat_idx;
	dbc_pkg::map_entry_s map_wdata, pe, fe;
	logic [`DBC_DATA_W-1:0] dat_wdata;
	logic hit_pri, hit_alt, cache_en, early_eff, last, more_host;
	logic [`DBC_CTRL_W-1:0] ctrl, next_ctrl;
	logic [`DBC_CNT_W-1:0] lookahead, next_lookahead;
	logic [`DBC_REG_DATA_W-1:0] next_reg_rdata;

	function automatic logic tag_hit(input dbc_pkg::map_entry_s e,
			input logic [`DBC_DRV_W-1:0] d, input logic [`DBC_LBA_W-1:0] l);
		tag_hit = e.valid && e.drive == d && e.lba == l;
	endfunction

	function automatic dbc_pkg::map_entry_s settle(input dbc_pkg::map_entry_s e);
		settle = e;
		settle.locked = 1'b0;
		settle.pri_dirty = 1'b0;
		settle.shadow_dirty = 1'b0;
	endfunction

	function automatic dbc_pkg::disc_cmd_s disc_start(input logic w,
			input logic [`DBC_DRV_W-1:0] d, input logic [`DBC_LBA_W-1:0] l,
			input logic [`DBC_DATA_W-1:0] v);
		disc_start = '{req: 1'b1, write: w, drive: d, lba: l, wdata: v};
	endfunction

	//////////////////////////////////////////////////////////////////////////////
	slot_hash_if hs();
	slot_hash u_hash (.h(hs.hasher));

	assign cur_lba = base_lba + `DBC_LBA_W'(idx);
	assign hs.drive = cur_drive;
	assign hs.lba = cur_lba;
	assign pe = map[hs.primary];
	assign fe = map[flush_ptr];
	// alternate slot only compared, never written
	assign hit_pri = tag_hit(pe, cur_drive, cur_lba);
	assign hit_alt = tag_hit(map[hs.alternate], cur_drive, cur_lba);
	assign hit_slot = hit_pri ? hs.primary : hs.alternate;
	assign cache_en = ctrl[`DBC_CTRL_CACHE_EN];
	assign early_eff = ctrl[`DBC_CTRL_EARLY] & cache_en;
	assign last = (idx + `DBC_IDX_W'(1)) >= total;
	assign more_host = idx < {1'b0, count};

	//////////////////////////////////////////////////////////////////////////////
	always_comb begin
		next_state = state;
		next_disc = disc;
		next_op_write = op_write;
		next_cur_drive = cur_drive;
		next_base_lba = base_lba;
		next_count = count;
		next_idx = idx;
		next_total = total;
		next_cur_slot = cur_slot;
		next_flush_ptr = flush_ptr;
		next_done = 1'b0;
		next_rd_valid = 1'b0;
		next_rdata = host_rdata_o;
		next_wr_ready = host_wr_ready_o;
		map_we = 1'b0;
		map_idx = cur_slot;
		map_wdata = map[cur_slot];
		dat_we = 1'b0;
		dat_idx = cur_slot;
		dat_wdata = disc_rdata_i;
		case (state)
			dbc_pkg::S_IDLE: begin
				if (req_valid_i) begin
					next_op_write = req_write_i;
					next_cur_drive = req_drive_i;
					next_base_lba = req_lba_i;
					next_count = req_count_i;
					next_idx = '0;
					next_total = {1'b0, req_count_i};
					if (req_count_i == '0)
						next_state = dbc_pkg::S_DONE;
					else if (req_write_i || !cache_en)
						next_state = dbc_pkg::S_ALLOC;
					else
						next_state = dbc_pkg::S_LOOKUP;
				end else if (fe.pri_dirty && !fe.locked) begin
					// background commit of early-notified data
					map_we = 1'b1;
					map_idx = flush_ptr;
					map_wdata = fe;
					map_wdata.locked = 1'b1;
					next_cur_slot = flush_ptr;
					next_disc = disc_start(1'b1, fe.drive, fe.lba, dat[flush_ptr]);
					next_state = dbc_pkg::S_FLUSH;
				end else begin
					next_flush_ptr = flush_ptr + `DBC_SLOT_W'(1);
				end
			end
			dbc_pkg::S_LOOKUP: begin
				if (!(hit_pri || hit_alt)) begin
					next_idx = '0;
					next_total = {1'b0, count} + {1'b0, lookahead};
					next_state = dbc_pkg::S_ALLOC;
				end else if (last) begin
					next_idx = '0;
					next_state = dbc_pkg::S_HIT_XFER;
				end else begin
					next_idx = idx + `DBC_IDX_W'(1);
				end
			end
			dbc_pkg::S_HIT_XFER: begin
				next_rd_valid = 1'b1;
				next_rdata = dat[hit_slot];
				if (last)
					next_state = dbc_pkg::S_DONE;
				else
					next_idx = idx + `DBC_IDX_W'(1);
			end
			dbc_pkg::S_ALLOC: begin
				next_cur_slot = hs.primary;
				if (pe.locked) begin
					next_state = dbc_pkg::S_ALLOC;
				end else if (pe.pri_dirty && !hit_pri) begin
					map_we = 1'b1;
					map_idx = hs.primary;
					map_wdata = pe;
					map_wdata.locked = 1'b1;
					next_disc = disc_start(1'b1, pe.drive, pe.lba, dat[hs.primary]);
					next_state = dbc_pkg::S_EVICT;
				end else if (!op_write && cache_en && hit_pri) begin
					next_state = more_host ? dbc_pkg::S_DELIVER : dbc_pkg::S_NEXT;
				end else begin
					map_we = 1'b1;
					map_idx = hs.primary;
					map_wdata = '{locked: 1'b1, valid: 1'b0, pri_dirty: 1'b0,
						shadow_dirty: 1'b0, drive: cur_drive, lba: cur_lba};
					if (op_write) begin
						next_wr_ready = 1'b1;
						next_state = dbc_pkg::S_WR_HOST;
					end else begin
						next_disc = disc_start(1'b0, cur_drive, cur_lba, '0);
						next_state = dbc_pkg::S_DISC_RD;
					end
				end
			end
			dbc_pkg::S_DISC_RD: begin
				if (disc_ack_i) begin
					next_disc.req = 1'b0;
					dat_we = 1'b1;
					map_we = 1'b1;
					map_wdata = settle(map[cur_slot]);
					map_wdata.valid = 1'b1;
					next_state = more_host ? dbc_pkg::S_DELIVER : dbc_pkg::S_NEXT;
				end
			end
			dbc_pkg::S_DELIVER: begin
				next_rd_valid = 1'b1;
				next_rdata = dat[cur_slot];
				next_state = dbc_pkg::S_NEXT;
			end
			dbc_pkg::S_WR_HOST: begin
				if (host_wr_valid_i && host_wr_ready_o) begin
					next_wr_ready = 1'b0;
					dat_we = 1'b1;
					dat_wdata = host_wdata_i;
					map_we = 1'b1;
					map_wdata.valid = 1'b1;
					map_wdata.pri_dirty = 1'b1;
					map_wdata.shadow_dirty = 1'b1;
					if (early_eff) begin
						map_wdata.locked = 1'b0;
						next_state = dbc_pkg::S_NEXT;
					end else begin
						next_disc = disc_start(1'b1, cur_drive, cur_lba, host_wdata_i);
						next_state = dbc_pkg::S_DISC_WR;
					end
				end
			end
			dbc_pkg::S_DISC_WR, dbc_pkg::S_EVICT, dbc_pkg::S_FLUSH: begin
				if (disc_ack_i) begin
					next_disc.req = 1'b0;
					map_we = 1'b1;
					map_wdata = settle(map[cur_slot]);
					if (state == dbc_pkg::S_DISC_WR)
						next_state = dbc_pkg::S_NEXT;
					else if (state == dbc_pkg::S_EVICT)
						next_state = dbc_pkg::S_ALLOC;
					else
						next_state = dbc_pkg::S_IDLE;
				end
			end
			dbc_pkg::S_NEXT: begin
				if (last) begin
					next_state = dbc_pkg::S_DONE;
				end else begin
					next_idx = idx + `DBC_IDX_W'(1);
					next_state = dbc_pkg::S_ALLOC;
				end
			end
			dbc_pkg::S_DONE: begin
				next_done = 1'b1;
				next_state = dbc_pkg::S_IDLE;
			end
			default: next_state = dbc_pkg::S_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i) begin
			state <= dbc_pkg::S_IDLE;
			disc <= '0;
			op_write <= 1'b0;
			cur_drive <= '0;
			base_lba <= '0;
			count <= '0;
			idx <= '0;
			total <= '0;
			cur_slot <= '0;
			flush_ptr <= '0;
			busy_o <= 1'b0;
			done_o <= 1'b0;
			host_rd_valid_o <= 1'b0;
			host_rdata_o <= '0;
			host_wr_ready_o <= 1'b0;
			for (int i = 0; i < `DBC_NUM_SLOTS; i++)
				map[i] <= '0;
		end else begin
			state <= next_state;
			disc <= next_disc;
			op_write <= next_op_write;
			cur_drive <= next_cur_drive;
			base_lba <= next_base_lba;
			count <= next_count;
			idx <= next_idx;
			total <= next_total;
			cur_slot <= next_cur_slot;
			flush_ptr <= next_flush_ptr;
			busy_o <= next_state != dbc_pkg::S_IDLE;
			done_o <= next_done;
			host_rd_valid_o <= next_rd_valid;
			host_rdata_o <= next_rdata;
			host_wr_ready_o <= next_wr_ready;
			if (map_we)
				map[map_idx] <= map_wdata;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (dat_we)
			dat[dat_idx] <= dat_wdata;
	end

	assign disc_req_o = disc.req;
	assign disc_write_o = disc.write;
	assign disc_drive_o = disc.drive;
	assign disc_lba_o = disc.lba;
	assign disc_wdata_o = disc.wdata;

	//////////////////////////////////////////////////////////////////////////////
	// register port
	always_comb begin
		next_ctrl = ctrl;
		next_lookahead = lookahead;
		next_reg_rdata = '0;
		if (reg_wr_i) begin
			if (reg_addr_i == `DBC_REG_CTRL)
				next_ctrl = reg_wdata_i[`DBC_CTRL_W-1:0];
			else if (reg_addr_i == `DBC_REG_LOOKAHEAD)
				next_lookahead = reg_wdata_i[`DBC_CNT_W-1:0];
		end
		if (reg_rd_i) begin
			if (reg_addr_i == `DBC_REG_CTRL)
				next_reg_rdata = `DBC_REG_DATA_W'(ctrl);
			else if (reg_addr_i == `DBC_REG_LOOKAHEAD)
				next_reg_rdata = `DBC_REG_DATA_W'(lookahead);
			else if (reg_addr_i == `DBC_REG_STATUS)
				next_reg_rdata = `DBC_REG_DATA_W'({busy_o, state});
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i) begin
			ctrl <= `DBC_CTRL_RESET;
			lookahead <= `DBC_LOOKAHEAD_RESET;
			reg_rdata_o <= '0;
		end else begin
			ctrl <= next_ctrl;
			lookahead <= next_lookahead;
			reg_rdata_o <= next_reg_rdata;
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!resetn_i);

	sequence s_wr_taken;
		state == dbc_pkg::S_WR_HOST && host_wr_valid_i && host_wr_ready_o;
	endsequence
	sequence s_rd_done;
		state == dbc_pkg::S_DISC_RD && disc_ack_i;
	endsequence

	a_primary_hash: assert property (`DBC_SLOT_W'(hs.primary - dbc_pkg::drive_bias(cur_drive))
		== `DBC_SLOT_W'(cur_lba % `DBC_LBA_W'(`DBC_NUM_SLOTS)))
		else $error("primary slot not block modulo plus drive bias");
	a_alternate_half: assert property (`DBC_SLOT_W'(hs.alternate - hs.primary)
		== `DBC_HALF_SLOTS)
		else $error("alternate slot not half the cache away");
	a_alloc_primary: assert property (map_we && state == dbc_pkg::S_ALLOC
		|-> map_idx == hs.primary)
		else $error("allocation outside the primary slot");
	a_hit_no_disc: assert property (state == dbc_pkg::S_HIT_XFER
		|-> !disc_req_o ##1 host_rd_valid_o)
		else $error("cache hit touched disc or gave no data");
	a_lock_stall: assert property (state == dbc_pkg::S_ALLOC && pe.locked
		|=> state == dbc_pkg::S_ALLOC && !disc_req_o)
		else $error("locked slot did not stall");
	a_read_unlock: assert property (s_rd_done
		|=> map[$past(cur_slot)].valid && !map[$past(cur_slot)].locked)
		else $error("read miss slot not valid and unlocked");
	a_write_through: assert property (s_wr_taken ##0 !early_eff
		|=> disc_req_o && disc_write_o && map[cur_slot].locked ##0 map[cur_slot].valid)
		else $error("write-through did not hold lock into disc write");
	a_cache_off: assert property (state == dbc_pkg::S_IDLE && req_valid_i && !req_write_i
		&& !cache_en && req_count_i != '0 |=> state == dbc_pkg::S_ALLOC)
		else $error("disabled cache looked up a read");
	a_early_notify: assert property (s_wr_taken ##0 early_eff
		|=> !disc_req_o && !map[cur_slot].locked && map[cur_slot].pri_dirty)
		else $error("early notified write not left unwritten in cache");
	a_lookahead_len: assert property (state == dbc_pkg::S_LOOKUP && !(hit_pri || hit_alt)
		|=> total == {1'b0, count} + {1'b0, $past(lookahead)})
		else $error("miss length ignores look-ahead");
	a_contig_slots: assert property (state == dbc_pkg::S_NEXT && !last
		|=> hs.primary == `DBC_SLOT_W'($past(hs.primary) + `DBC_SLOT_W'(1)))
		else $error("transfer slots not contiguous");
	a_evict_first: assert property (state == dbc_pkg::S_ALLOC && !pe.locked && pe.pri_dirty
		&& !hit_pri |=> state == dbc_pkg::S_EVICT && disc_req_o && disc_write_o)
		else $error("unwritten slot reassigned without disc write");
endmodule

// ---- sim/disc_seq_model.sv ----
// stand-in for the disc transfer sequencer: block store with adjustable answer delay
`include "dbc_consts.svh"
module disc_seq_model (
	input wire logic ref_clk_i,
	input wire logic resetn_i,
	input wire logic disc_req_i,
	input wire logic disc_write_i,
	input wire logic [`DBC_DRV_W-1:0] disc_drive_i,
	input wire logic [`DBC_LBA_W-1:0] disc_lba_i,
	input wire logic [`DBC_DATA_W-1:0] disc_wdata_i,
	input wire logic [3:0] delay_i,
	output logic disc_ack_o,
	output logic [`DBC_DATA_W-1:0] disc_rdata_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] store [bit [27:0]];
	logic [3:0] wait_cnt;
	int n_rd;
	int n_wr;
	logic [`DBC_LBA_W-1:0] last_lba;
	logic [15:0] last_data;
	function automatic logic [15:0] peek(input bit [27:0] k);
		peek = store.exists(k) ? store[k] : 16'hDEAD;
	endfunction
	////////////////////////////////////////
	// data line toggles whenever no answer stands on it
	always @(posedge ref_clk_i) begin
		if (!resetn_i) begin
			disc_ack_o <= 1'h0;
			disc_rdata_o <= 16'h5555;
			wait_cnt <= 4'h0;
			n_rd <= 0;
			n_wr <= 0;
		end else if (disc_ack_o) begin
			disc_ack_o <= 1'h0;
			disc_rdata_o <= ~disc_rdata_o;
		end else if (disc_req_i && wait_cnt >= delay_i) begin
			disc_ack_o <= 1'h1;
			wait_cnt <= 4'h0;
			last_lba <= disc_lba_i;
			if (disc_write_i) begin
				store[{disc_drive_i, disc_lba_i}] = disc_wdata_i;
				n_wr <= n_wr + 1;
				last_data <= disc_wdata_i;
				disc_rdata_o <= ~disc_rdata_o;
			end else begin
				n_rd <= n_rd + 1;
				disc_rdata_o <= store.exists({disc_drive_i, disc_lba_i}) ?
					store[{disc_drive_i, disc_lba_i}] : ({disc_drive_i, disc_lba_i[13:0]} ^ 16'h3C3C);
			end
		end else begin
			wait_cnt <= disc_req_i ? wait_cnt + 4'h1 : 4'h0;
			disc_rdata_o <= ~disc_rdata_o;
		end
	end
endmodule

// ---- sim/test_disc_block_cache_manager.sv ----
// self-checking bench of the disc block cache manager
`include "dbc_consts.svh"
module test_disc_block_cache_manager;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int LIMIT = 30000;
	logic ref_clk_i = 1'h0;
	logic resetn_i = 1'h0;
	logic [`DBC_REG_ADDR_W-1:0] reg_addr_i = 8'h00;
	logic [`DBC_REG_DATA_W-1:0] reg_wdata_i = 32'h0;
	logic reg_wr_i = 1'h0;
	logic reg_rd_i = 1'h0;
	logic [`DBC_REG_DATA_W-1:0] reg_rdata_o;
	logic req_valid_i = 1'h0;
	logic req_write_i = 1'h0;
	logic [`DBC_DRV_W-1:0] req_drive_i = 2'h0;
	logic [`DBC_LBA_W-1:0] req_lba_i = 26'h0;
	logic [`DBC_CNT_W-1:0] req_count_i = 8'h00;
	logic busy_o, done_o, host_rd_valid_o, host_wr_ready_o;
	logic [`DBC_DATA_W-1:0] host_rdata_o, disc_wdata_o, disc_rdata_i;
	logic host_wr_valid_i = 1'h0;
	logic [`DBC_DATA_W-1:0] host_wdata_i = 16'h0;
	logic disc_req_o, disc_write_o, disc_ack_i;
	logic [`DBC_DRV_W-1:0] disc_drive_o;
	logic [`DBC_LBA_W-1:0] disc_lba_o;
	logic [3:0] delay = 4'h3;
	int err_count = 0;
	int compares = 0;
	int cyc = 0;
	int taken;
	logic [15:0] words [$];

	disc_block_cache_manager dut_u (.ref_clk_i, .resetn_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
		.reg_rd_i, .reg_rdata_o, .req_valid_i, .req_write_i, .req_drive_i, .req_lba_i,
		.req_count_i, .busy_o, .done_o, .host_rd_valid_o, .host_rdata_o, .host_wr_valid_i,
		.host_wdata_i, .host_wr_ready_o, .disc_req_o, .disc_write_o, .disc_drive_o, .disc_lba_o,
		.disc_wdata_o, .disc_ack_i, .disc_rdata_i);
	disc_seq_model disc_u (.ref_clk_i, .resetn_i, .disc_req_i(disc_req_o),
		.disc_write_i(disc_write_o), .disc_drive_i(disc_drive_o), .disc_lba_i(disc_lba_o),
		.disc_wdata_i(disc_wdata_o), .delay_i(delay), .disc_ack_o(disc_ack_i),
		.disc_rdata_o(disc_rdata_i));

	always #5 ref_clk_i = ~ref_clk_i;
	always @(posedge ref_clk_i) begin
		cyc++;
		if (cyc == LIMIT) begin
			err_count++;
			end_sim();
		end
	end
	////////////////////////////////////////
	function automatic logic [15:0] host_pat(input logic [1:0] d, input logic [25:0] l);
		host_pat = {d, l[13:0]} ^ 16'h3C3C;
	endfunction
	task automatic end_sim();
		$display("compares %0d mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			err_count++;
			$display("FAIL %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic reg_wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge ref_clk_i);
		reg_wr_i <= 1'h1;
		reg_addr_i <= a;
		reg_wdata_i <= v;
		@(posedge ref_clk_i);
		reg_wr_i <= 1'h0;
	endtask
	task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp, input string what);
		@(posedge ref_clk_i);
		reg_rd_i <= 1'h1;
		reg_addr_i <= a;
		@(posedge ref_clk_i);
		reg_rd_i <= 1'h0;
		@(negedge ref_clk_i);
		check(what, reg_rdata_o, exp);
	endtask
	// one single-block request; request held until the engine is idle, one host word offered
	task automatic xfer(input logic wr, input logic [1:0] d, input logic [25:0] l);
		int k;
		k = 0;
		taken = 0;
		words.delete();
		@(posedge ref_clk_i);
		req_valid_i <= 1'h1;
		req_write_i <= wr;
		req_drive_i <= d;
		req_lba_i <= l;
		req_count_i <= 8'h01;
		host_wr_valid_i <= wr;
		host_wdata_i <= host_pat(d, l);
		do begin
			@(negedge ref_clk_i);
			k++;
		end while (busy_o !== 1'h0 && k < 2000);
		@(posedge ref_clk_i);
		req_valid_i <= 1'h0;
		while (k < 4000) begin
			@(negedge ref_clk_i);
			k++;
			if (host_rd_valid_o === 1'h1) words.push_back(host_rdata_o);
			if (done_o === 1'h1) break;
			if (host_wr_valid_i && host_wr_ready_o === 1'h1) begin
				taken++;
				@(posedge ref_clk_i);
				host_wr_valid_i <= 1'h0;
			end
		end
		check("done seen", {31'h0, done_o}, 32'h1);
		check("host words", wr ? taken : words.size(), 32'h1);
	endtask
	task automatic read_chk(input logic [1:0] d, input logic [25:0] l, input int disc_reads);
		int r0;
		r0 = disc_u.n_rd;
		xfer(1'h0, d, l);
		check("read word", {16'h0, words[0]}, {16'h0, host_pat(d, l)});
		check("disc reads", disc_u.n_rd - r0, disc_reads);
	endtask
	task automatic write_chk(input logic [1:0] d, input logic [25:0] l, input int disc_writes);
		int w0;
		w0 = disc_u.n_wr;
		xfer(1'h1, d, l);
		check("disc writes at done", disc_u.n_wr - w0, disc_writes);
	endtask
	////////////////////////////////////////
	task automatic t_regs();
		reg_rd(`DBC_REG_CTRL, 32'h3, "ctrl reset");
		reg_rd(`DBC_REG_LOOKAHEAD, 32'h4, "lookahead reset");
		reg_rd(8'h0C, 32'h0, "unmapped");
		reg_wr(`DBC_REG_LOOKAHEAD, 32'h1FF);
		reg_rd(`DBC_REG_LOOKAHEAD, 32'hFF, "lookahead max");
		reg_wr(`DBC_REG_LOOKAHEAD, 32'h0);
		reg_wr(`DBC_REG_CTRL, 32'h1);
		reg_rd(`DBC_REG_CTRL, 32'h1, "ctrl early off");
	endtask
	task automatic t_through_and_hits();
		write_chk(2'h0, 26'h100, 1);
		check("written word", {16'h0, disc_u.last_data}, {16'h0, host_pat(2'h0, 26'h100)});
		delay = 4'h0;
		read_chk(2'h0, 26'h100, 0);
		write_chk(2'h1, 26'h100, 1);
		read_chk(2'h0, 26'h100, 0);
		read_chk(2'h1, 26'h100, 0);
		write_chk(2'h0, 26'h140, 1);
		read_chk(2'h0, 26'h100, 1);
		read_chk(2'h0, 26'h100, 0);
	endtask
	task automatic t_lookahead();
		delay = 4'h5;
		reg_wr(`DBC_REG_LOOKAHEAD, 32'h2);
		read_chk(2'h2, 26'h200, 3);
		check("last ahead block", {6'h0, disc_u.last_lba}, 32'h202);
		read_chk(2'h2, 26'h202, 0);
		reg_wr(`DBC_REG_LOOKAHEAD, 32'h0);
		read_chk(2'h2, 26'h300, 1);
	endtask
	task automatic t_early();
		int k;
		int w0;
		reg_wr(`DBC_REG_CTRL, 32'h3);
		w0 = disc_u.n_wr;
		write_chk(2'h3, 26'h50, 0);
		xfer(1'h1, 2'h3, 26'h90);
		for (k = 0; k < 600 && disc_u.n_wr < w0 + 2; k++) @(negedge ref_clk_i);
		check("flushed writes", disc_u.n_wr - w0, 2);
		check("evicted word", {16'h0, disc_u.peek({2'h3, 26'h50})}, {16'h0, host_pat(2'h3, 26'h50)});
		check("flushed word", {16'h0, disc_u.peek({2'h3, 26'h90})}, {16'h0, host_pat(2'h3, 26'h90)});
		read_chk(2'h3, 26'h90, 0);
	endtask
	task automatic t_disable();
		reg_wr(`DBC_REG_LOOKAHEAD, 32'h2);
		reg_wr(`DBC_REG_CTRL, 32'h2);
		read_chk(2'h0, 26'h100, 1);
		write_chk(2'h1, 26'h77, 1);
		read_chk(2'h1, 26'h77, 1);
	endtask
	initial begin
		repeat (20) @(posedge ref_clk_i);
		resetn_i <= 1'h1;
		t_regs();
		t_through_and_hits();
		t_lookahead();
		t_early();
		t_disable();
		end_sim();
	end
endmodule
